// ==== hdl/rsc_device.sv ====
// module: rheostat serial command core, device end of the link
// Function
// RULE1 - frame: two zero bits, command, ten data
// RULE2 - bits shift in MSB first
// RULE3 - 256 variant ignores two low data bits
// RULE4 - host holds sync low whole word
// RULE5 - decode word on sync rising edge
// RULE6 - frames counted in multiples of sixteen bits
// RULE7 - no serial clock needed between frames
// RULE8 - wiper register drives tap, zero is A
// RULE9 - command 1 loads wiper register
// RULE10 - command 3 stores wiper into fuse slot
// RULE11 - slots start at 1, at most 50
// RULE12 - store locks shift register about 350 ms
// RULE13 - fuse program done bit readable
// RULE14 - unprogrammed power-up gives midscale
// RULE15 - power-up restores last stored value; rst_n clears lastSlot here, so power-up gives midscale
// RULE16 - wiper write enable resets zero, blocks
// RULE17 - command 7 sets wiper write enable
// RULE18 - fuse program enable resets zero, gates store
// RULE19 - sample data on serial clock falling edges
// RULE20 - short frame discarded, nothing changes
// RULE21 - command 4 reloads last slot or midscale
// RULE22 - command 7 writes control, 8 reads
// RULE23 - midscale is only data MSB set
module rsc_device
  import rsc_pkg::*;
#(
  parameter int STORE_LOCK = rsc_pkg::STORE_CYCLES,
  parameter bit NARROW = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  rsc_link_if.device link,
  output logic [9:0] wiperTap,
  output logic storeBusy,
  output logic shutdown
);
  import rsc_pkg::*;

  logic syncS, sclkS, dinS;
  logic syncD, sclkD;
  logic [15:0] shiftIn;
  logic [15:0] shiftOut;
  logic [3:0] bitCount;
  logic frameFull;
  logic [2:0] ctrl;
  logic fuseDone;
  logic [9:0] wiper;
  logic [9:0] fuseMem [1:SLOT_COUNT];
  logic [5:0] lastSlot;
  logic [31:0] lockCount;
  logic booted;
  logic [15:0] nextOut;
  logic [9:0] restoreValue;

  rsc_sync2 uSync (.clk_sys(clk_sys), .rst_n(rst_n), .d(link.syncN), .q(syncS));
  rsc_sync2 uSclk (.clk_sys(clk_sys), .rst_n(rst_n), .d(link.sclk), .q(sclkS));
  rsc_sync2 uDin (.clk_sys(clk_sys), .rst_n(rst_n), .d(link.din), .q(dinS));

  // edge detection only after the synchroniser; a parked clock simply yields no edges
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncD <= 1'b1;
      sclkD <= 1'b1;
    end
    else
    begin
      syncD <= syncS;
      sclkD <= sclkS; // RULE7
    end
  end

  wire sclkFall = sclkD && !sclkS && !syncS; // RULE19
  wire syncRise = !syncD && syncS; // RULE5
  wire syncFall = syncD && !syncS;
  wire [3:0] cmd = shiftIn[CMD_MSB:CMD_LSB]; // RULE1
  wire [9:0] data = shiftIn[DATA_BITS-1:0];
  wire locked = lockCount != 32'h0;
  wire decodeNow = syncRise && frameFull && bitCount == 4'h0 && !locked; // RULE6 RULE20 RULE12

  // restore source: last programmed slot, or midscale when none
  always_comb
  begin
    restoreValue = MIDSCALE; // RULE14 RULE23
    if (lastSlot != 6'h00)
      restoreValue = fuseMem[lastSlot]; // RULE15 RULE21
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shiftIn <= 16'h0000;
      bitCount <= 4'h0;
      frameFull <= 1'b0;
    end
    else if (syncFall)
    begin
      bitCount <= 4'h0;
      frameFull <= 1'b0;
    end
    // input shift register frozen while a store is under way
    else if (sclkFall && !locked) // RULE12
    begin
      shiftIn <= {shiftIn[14:0], dinS}; // RULE2
      bitCount <= bitCount + 4'h1; // RULE6
      if (bitCount == 4'hf)
        frameFull <= 1'b1;
    end
  end

  // readback register loaded on decode, shifted out on falling edges of the next frame
  always_comb
  begin
    nextOut = shiftIn; // daisy-chain echo by default
    case (cmd)
      CMD_READ_WIPER: nextOut = {6'h00, NARROW ? {wiper[9:2], 2'b00} : wiper}; // RULE3
      CMD_READ_SLOT: nextOut = {6'h00, (data[5:0] >= FIRST_SLOT && data[5:0] <= 6'(SLOT_COUNT))
                                 ? fuseMem[data[5:0]] : 10'h000};
      CMD_READ_LAST: nextOut = {10'h000, lastSlot};
      CMD_READ_CTRL: nextOut = {12'h000, fuseDone, ctrl}; // RULE13 RULE22
      default: nextOut = shiftIn;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      shiftOut <= 16'h0000;
    else if (decodeNow)
      shiftOut <= nextOut;
    else if (sclkFall)
      shiftOut <= {shiftOut[14:0], 1'b0};
  end

  assign link.sdoOut = 1'b0;
  assign link.sdoOe = !syncS && !shiftOut[15];

  // control bits
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= CTRL_RESET; // RULE16 RULE18
    else if (decodeNow && cmd == CMD_WRITE_CTRL)
      ctrl <= data[2:0]; // RULE17 RULE22
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      shutdown <= 1'b0;
    else if (decodeNow && cmd == CMD_SHUTDOWN)
      shutdown <= data[0];
    else if (decodeNow && cmd == CMD_SOFT_RESET)
      shutdown <= 1'b0;
  end

  // wiper register; first cycle after reset loads restoreValue, which is midscale because rst_n clears lastSlot
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wiper <= MIDSCALE;
      booted <= 1'b0;
    end
    else if (!booted)
    begin
      wiper <= restoreValue; // RULE14 RULE15
      booted <= 1'b1;
    end
    else if (decodeNow && cmd == CMD_SOFT_RESET)
      wiper <= restoreValue; // RULE21 RULE16
    else if (decodeNow && cmd == CMD_WRITE_WIPER && ctrl[CTRL_WIPER_EN])
      wiper <= NARROW ? {data[9:2], 2'b00} : data; // RULE9 RULE3 RULE17
  end

  assign wiperTap = wiper; // RULE8

  // fuse store: one slot per command, then a long lock
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lockCount <= 32'h0;
      fuseDone <= 1'b0;
    end
    // a full memory refuses the store outright, so no lock and done stays set
    else if (decodeNow && cmd == CMD_STORE && ctrl[CTRL_FUSE_EN] && lastSlot < 6'(SLOT_COUNT)) // RULE18 RULE11
    begin
      lockCount <= 32'(STORE_LOCK); // RULE12
      fuseDone <= 1'b0;
    end
    else if (lockCount == 32'h1)
    begin
      lockCount <= 32'h0;
      fuseDone <= 1'b1; // RULE13
    end
    else if (locked)
      lockCount <= lockCount - 32'h1;
  end

  // fuse array is not reset: it models nonvolatile content across rst_n
  always_ff @(posedge clk_sys)
  begin
    if (decodeNow && cmd == CMD_STORE && ctrl[CTRL_FUSE_EN] && lastSlot < 6'(SLOT_COUNT))
      fuseMem[lastSlot + 6'h01] <= wiper; // RULE10
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      lastSlot <= 6'h00;
    else if (decodeNow && cmd == CMD_STORE && ctrl[CTRL_FUSE_EN] && lastSlot < 6'(SLOT_COUNT))
      lastSlot <= lastSlot + 6'h01; // RULE11
  end

  assign storeBusy = locked;
endmodule

// ==== hdl/rsc_host.sv ====
// module: host controller end, sends 16-bit frames over the link
module rsc_host
  import rsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  rsc_link_if.host link,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  import rsc_pkg::*;

  rsc_host_state_type state;
  logic [15:0] txWord;
  logic [15:0] rxWord;
  logic [4:0] bitsLeft;
  logic [3:0] divCount;
  logic sdoS;
  logic syncN, sclk;

  rsc_sync2 uSdo (.clk_sys(clk_sys), .rst_n(rst_n), .d(link.serial_data_out), .q(sdoS));

  wire tick = divCount == 4'(SCLK_HALF - 1);
  wire busy = state != H_IDLE;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      divCount <= 4'h0;
    else if (!busy || tick)
      divCount <= 4'h0;
    else
      divCount <= divCount + 4'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= H_IDLE;
      syncN <= 1'b1;
      sclk <= 1'b1;
      txWord <= 16'h0000;
      rxWord <= 16'h0000;
      bitsLeft <= 5'h00;
    end
    else
    begin
      case (state)
        H_IDLE:
          if (wr && addr == HOST_ADDR_CMD)
          begin
            txWord <= {2'b00, wdata[13:0]}; // RULE1
            bitsLeft <= 5'h10;
            syncN <= 1'b0; // RULE4
            state <= H_SHIFT;
          end
        H_SHIFT:
          if (tick)
          begin
            if (sclk)
            begin
              sclk <= 1'b0; // RULE19
              rxWord <= {rxWord[14:0], sdoS};
              bitsLeft <= bitsLeft - 5'h01;
            end
            else if (bitsLeft == 5'h00)
            begin
              sclk <= 1'b1;
              state <= H_GAP; // RULE6
            end
            else
            begin
              sclk <= 1'b1;
              txWord <= {txWord[14:0], 1'b0}; // RULE2
            end
          end
        H_GAP:
          if (tick)
          begin
            syncN <= 1'b1; // RULE4
            state <= H_IDLE;
          end
        default: state <= H_IDLE;
      endcase
    end
  end

  assign link.syncN = syncN;
  assign link.sclk = sclk;
  assign link.din = txWord[15];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0;
    else if (rd && addr == HOST_ADDR_STATUS)
      rdata <= {31'h0, busy};
    else if (rd && addr == HOST_ADDR_READ)
      rdata <= {16'h0, rxWord}; // RULE13
    else
      rdata <= 32'h0;
  end
endmodule

// ==== hdl/rsc_link_if.sv ====
// interface: four-wire serial link between host and rheostat core
interface rsc_link_if;
  logic syncN;
  logic sclk;
  logic din;
  logic sdoOut;
  logic sdoOe;
  logic serial_data_out;
  // open drain with pull-up: low only while the device pulls
  assign serial_data_out = sdoOe ? sdoOut : 1'b1;
  modport device (input syncN, input sclk, input din, output sdoOut, output sdoOe);
  modport host (output syncN, output sclk, output din, input serial_data_out);
endinterface

// ==== hdl/rsc_pkg.sv ====
// package: constants and types shared by the rheostat serial command ends
package rsc_pkg;
  localparam int FRAME_BITS = 16;
  localparam int DATA_BITS = 10;
  localparam int CMD_LSB = 10;
  localparam int CMD_MSB = 13;
  localparam int SLOT_COUNT = 50;
  localparam logic [5:0] FIRST_SLOT = 6'h01;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WRITE_WIPER = 4'h1;
  localparam logic [3:0] CMD_READ_WIPER = 4'h2;
  localparam logic [3:0] CMD_STORE = 4'h3;
  localparam logic [3:0] CMD_SOFT_RESET = 4'h4;
  localparam logic [3:0] CMD_READ_SLOT = 4'h5;
  localparam logic [3:0] CMD_READ_LAST = 4'h6;
  localparam logic [3:0] CMD_WRITE_CTRL = 4'h7;
  localparam logic [3:0] CMD_READ_CTRL = 4'h8;
  localparam logic [3:0] CMD_SHUTDOWN = 4'h9;
  localparam logic [9:0] MIDSCALE = 10'h200;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int CTRL_FUSE_EN = 0;
  localparam int CTRL_WIPER_EN = 1;
  localparam int CTRL_PERF = 2;
  // fuse store lock time, microseconds, at 100 MHz
  localparam int STORE_TIME_US = 350000;
  localparam int CLK_MHZ = 100;
  localparam int STORE_CYCLES = STORE_TIME_US * CLK_MHZ;
  // host serial clock divider: half period in system clocks (160 ns period)
  localparam int SCLK_HALF = 8;
  // host register port offsets
  localparam logic [3:0] HOST_ADDR_CMD = 4'h0;
  localparam logic [3:0] HOST_ADDR_STATUS = 4'h4;
  localparam logic [3:0] HOST_ADDR_READ = 4'h8;
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_SHIFT = 3'b010,
    H_GAP = 3'b100
  } rsc_host_state_type;
endpackage

// ==== hdl/rsc_sync2.sv ====
// module: two-flip-flop synchroniser for one level
module rsc_sync2 (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic stage1;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= 1'b1;
      q <= 1'b1;
    end
    else
    begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule

// ==== sim/rsc_chk.sv ====
// checker: wire-level behaviour of the host-to-device serial link
module rsc_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic syncN,
  input wire logic sclk,
  input wire logic din
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] lowCnt;
  logic [4:0] fallCnt;
  logic sclkQ;
  // saturates so a stuck sync cannot wrap back into range
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      lowCnt <= 9'h000;
    else if (syncN)
      lowCnt <= 9'h000;
    else if (lowCnt != 9'h1ff)
      lowCnt <= lowCnt + 9'h001;
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      fallCnt <= 5'h00;
    else if (syncN)
      fallCnt <= 5'h00;
    else if (sclkQ && !sclk)
      fallCnt <= fallCnt + 5'h01;
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sclkQ <= 1'b1;
    else
      sclkQ <= sclk;
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence frameStart;
    $fell(syncN);
  endsequence
  sequence firstFall;
    sclk [*8] ##1 !sclk;
  endsequence
  idle_high_a: assert property (syncN |-> sclk)
    else $error("serial clock moved outside a frame");
  sync_hold_a: assert property ($rose(syncN) |-> lowCnt >= 9'h100)
    else $error("sync released before the word was shifted");
  frame_count_a: assert property ($rose(syncN) |-> fallCnt == 5'h10)
    else $error("frame did not carry sixteen clock falls");
  lead_zero_a: assert property ($fell(sclk) && !syncN && fallCnt < 5'h02 |-> !din)
    else $error("leading unused bit not zero");
  din_settled_a: assert property ($fell(sclk) |-> $stable(din))
    else $error("data changed on the sampling edge");
  half_period_a: assert property ($changed(sclk) |=> $stable(sclk) [*7])
    else $error("serial clock half period too short");
  first_fall_a: assert property (frameStart |-> firstFall)
    else $error("first clock fall not eight cycles after sync");
  late_edge_a: assert property ($rose(syncN) |-> sclk && $past(sclk, 8))
    else $error("sync rose too soon after the last clock rise");
endmodule

// ==== sim/tb_rheostat_serial_command_core.sv ====
// testbench: host and device ends joined, plus a bench-driven second link
module tb_rheostat_serial_command_core;
  timeunit 1ns;
  timeprecision 100ps;
  import rsc_pkg::*;
  typedef struct packed {
    logic [15:0] word;
    logic [9:0] wiper;
    logic [15:0] rx;
    logic [15:0] mask;
  } rsc_row_type;
  // rx is the reply to the previous row's frame
  localparam rsc_row_type ROWS [12] = '{
    '{16'h0555, 10'h200, 16'h0000, 16'h0000}, '{16'h0c00, 10'h200, 16'h0555, 16'hffff},
    '{16'h1c03, 10'h200, 16'h0c00, 16'hffff}, '{16'h0400, 10'h000, 16'h1c03, 16'hffff},
    '{16'h07ff, 10'h3ff, 16'h0400, 16'hffff}, '{16'h0523, 10'h123, 16'h07ff, 16'hffff},
    '{16'h0800, 10'h123, 16'h0523, 16'hffff}, '{16'h2000, 10'h123, 16'h0123, 16'h03ff},
    '{16'h1c02, 10'h123, 16'h0003, 16'h0007}, '{16'h0c00, 10'h123, 16'h1c02, 16'hffff},
    '{16'h2000, 10'h123, 16'h0c00, 16'hffff}, '{16'h0000, 10'h123, 16'h0002, 16'h0007}};
  logic clk_sys = 1'b0;
  logic rst_n;
  logic [3:0] hAddr;
  logic [31:0] hWdata;
  logic hWr;
  logic hRd;
  logic [31:0] hRdata;
  logic [9:0] wiperTap;
  logic [9:0] wiperB;
  logic storeBusy;
  logic shutB;
  logic [15:0] rx;
  int error_cnt = 0;
  int comparisons = 0;
  rsc_link_if link();
  rsc_link_if linkB();
  rsc_host rsc_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .addr(hAddr), .wdata(hWdata),
    .wr(hWr), .rd(hRd), .rdata(hRdata));
  // lock kept longer than one frame so a frame can land inside it
  rsc_device #(.STORE_LOCK(400), .NARROW(1'b0)) rsc_device_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link), .wiperTap(wiperTap), .storeBusy(storeBusy), .shutdown());
  rsc_device #(.STORE_LOCK(400), .NARROW(1'b1)) rsc_device_b_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(linkB), .wiperTap(wiperB), .storeBusy(), .shutdown(shutB));
  rsc_chk rsc_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .syncN(link.syncN), .sclk(link.sclk),
    .din(link.din));
  always #5 clk_sys = ~clk_sys;
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic put_reg(input logic [3:0] a, input logic [31:0] d);
    hAddr <= a;
    hWdata <= d;
    hWr <= 1'b1;
    @(posedge clk_sys);
    hWr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic get_reg(input logic [3:0] a, output logic [31:0] d);
    hAddr <= a;
    hRd <= 1'b1;
    @(posedge clk_sys);
    hRd <= 1'b0;
    @(posedge clk_sys);
    d = hRdata;
  endtask
  task automatic send(input logic [15:0] w, output logic [15:0] r);
    logic [31:0] s;
    int k;
    put_reg(HOST_ADDR_CMD, {16'h0000, w});
    s = 32'h1;
    for (k = 0; k < 200 && s[0] !== 1'b0; k++)
      get_reg(HOST_ADDR_STATUS, s);
    check(s[0], 1'b0);
    repeat (8) @(posedge clk_sys);
    get_reg(HOST_ADDR_READ, s);
    r = s[15:0];
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 600 && storeBusy !== 1'b0; k++)
      @(posedge clk_sys);
    check(storeBusy, 1'b0);
  endtask
  // data moves on the rising edge, half a clock before the device samples it
  task automatic bang(input logic [31:0] w, input int n);
    linkB.syncN <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      linkB.din <= w[i];
      repeat (8) @(posedge clk_sys);
      linkB.sclk <= 1'b0;
      repeat (8) @(posedge clk_sys);
      linkB.sclk <= 1'b1;
    end
    repeat (8) @(posedge clk_sys);
    linkB.syncN <= 1'b1;
    linkB.din <= ~linkB.din;
    repeat (16) @(posedge clk_sys);
  endtask
  initial
  begin
    // about 42k cycles expected; the limit leaves near double that
    #800000;
    error_cnt++;
    $display("BAD %0t: watchdog ran out", $time);
    close_out();
  end
  initial
  begin
    rst_n = 1'b0;
    hAddr = 4'h0;
    hWdata = 32'h0;
    hWr = 1'b0;
    hRd = 1'b0;
    linkB.syncN = 1'b1;
    linkB.sclk = 1'b1;
    linkB.din = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    check(wiperTap, MIDSCALE);
    check(storeBusy, 1'b0);
    $display("test reset done");
    foreach (ROWS[i])
    begin
      send(ROWS[i].word, rx);
      check(wiperTap, ROWS[i].wiper);
      check(rx & ROWS[i].mask, ROWS[i].rx);
      check(storeBusy, 1'b0);
    end
    $display("test table done");
    send(16'h1c03, rx);
    send(16'h06aa, rx);
    send(16'h0c00, rx);
    check(storeBusy, 1'b1);
    send(16'h0511, rx);
    wait_idle();
    check(wiperTap, 10'h2aa);
    send(16'h0455, rx);
    check(wiperTap, 10'h055);
    send(16'h1000, rx);
    check(wiperTap, 10'h2aa);
    send(16'h1800, rx);
    send(16'h2000, rx);
    check(rx[5:0], FIRST_SLOT);
    send(16'h0000, rx);
    check(rx[3], 1'b1);
    for (int n = 2; n <= SLOT_COUNT + 1; n++)
    begin
      send(16'h0c00, rx);
      check(storeBusy, n <= SLOT_COUNT);
      wait_idle();
    end
    send(16'h1800, rx);
    send(16'h1432, rx);
    check(rx[5:0], SLOT_COUNT);
    send(16'h0000, rx);
    check(rx[9:0], 10'h2aa);
    $display("test store done");
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    check(wiperTap, MIDSCALE);
    send(16'h0555, rx);
    check(wiperTap, MIDSCALE);
    $display("test second reset done");
    bang(32'h1c03, 16);
    bang(32'h07ff, 10);
    check(wiperB, MIDSCALE);
    bang(32'h07ff, 16);
    check(wiperB, 10'h3fc);
    bang(32'h0401_0500, 32);
    check(wiperB, 10'h100);
    bang(32'h2401, 16);
    check(shutB, 1'b1);
    bang(32'h1000, 16);
    check(shutB, 1'b0);
    check(wiperB, MIDSCALE);
    $display("test second link done");
    close_out();
  end
endmodule
